// *** src/ssp_slave_port.sv ***
// slave i2c port with two receive and two transmit byte registers
`timescale 1ns/1ps
module ssp_slave_port
	import ssp_pkg::*;
#(
	parameter logic [4:0] ADDR_HIGH = ADDR_HIGH_DEF
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       we_i,
	input  wire logic       re_i,
	output logic      [7:0] rdata_o,
	// interrupt
	output logic            irq_o,
	// i2c pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o
);
	// ***************************
	// registers and state
	// ***************************
	logic [7:0] rx0;
	logic [7:0] rx1;
	logic [7:0] tx0;
	logic [7:0] tx1;
	logic [3:0] ctl;
	logic [5:0] flags;
	logic [5:0] istat;
	logic [5:0] imask;
	ssp_state_e state;
	ssp_state_e next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic       full;
	logic       next_full;
	logic       rw;
	logic       next_rw;
	logic [1:0] idx;
	logic [1:0] next_idx;
	logic       next_oe;
	logic       rx_st;
	logic       tx_dn;
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [7:0] rd_mux;

	function automatic logic [7:0] tx_pick(input logic [1:0] i,
		input logic [7:0] b0, input logic [7:0] b1);
		if (i == 2'h0) begin
			return b0;
		end else if (i == 2'h1) begin
			return b1;
		end
		return IDLE_BYTE;
	endfunction

	// ***************************
	// pin synchronisers and bus events
	// ***************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_i};
			sda_sync <= {sda_sync[1:0], sda_i};
		end
	end

	wire scl_s    = scl_sync[1];
	wire scl_d    = scl_sync[2];
	wire sda_s    = sda_sync[1];
	wire sda_d    = sda_sync[2];
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;
	wire port_en  = ctl[CTL_EN];
	wire tx_ie    = ctl[CTL_IE];
	wire addr_hit = (shreg[7:1] == {ADDR_HIGH, ctl[1:0]});
	wire [7:0] rx_byte = {shreg[6:0], sda_s};
	wire [1:0] idx_inc = (idx == 2'h2) ? idx : idx + 2'h1;

	// ***************************
	// protocol state machine
	// ***************************
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_shreg = shreg;
		next_full  = full;
		next_rw    = rw;
		next_idx   = idx;
		rx_st      = 1'b0;
		tx_dn      = 1'b0;
		case (state)
			ST_ADDR: begin
				if (scl_rise) begin
					next_shreg = rx_byte;
					next_cnt   = cnt + 3'h1;
					next_full  = (cnt == 3'h7);
				end else if (scl_fall && full) begin
					next_full  = 1'b0;
					next_rw    = shreg[0];
					next_state = addr_hit ? ST_AACK : ST_IDLE;
				end
			end
			ST_AACK: begin
				if (scl_fall) begin
					next_cnt = 3'h0;
					next_idx = 2'h0;
					if (rw) begin
						next_state = ST_TX;
						next_shreg = tx_pick(2'h0, tx0, tx1);
					end else begin
						next_state = ST_RX;
					end
				end
			end
			ST_RX: begin
				if (scl_rise) begin
					next_shreg = rx_byte;
					next_cnt   = cnt + 3'h1;
					next_full  = (cnt == 3'h7);
					rx_st      = (cnt == 3'h7) && (idx != 2'h2);
				end else if (scl_fall && full) begin
					next_full  = 1'b0;
					next_state = ST_RACK;
				end
			end
			ST_RACK: begin
				if (scl_fall) begin
					next_state = ST_RX;
					next_cnt   = 3'h0;
					next_idx   = idx_inc;
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					next_shreg = {shreg[6:0], 1'b1};
					next_cnt   = cnt + 3'h1;
					if (cnt == 3'h7) begin
						tx_dn      = (idx != 2'h2);
						next_state = ST_TACK;
					end
				end
			end
			ST_TACK: begin
				if (scl_rise && sda_s) begin
					next_state = ST_IDLE;
				end else if (scl_fall) begin
					next_state = ST_TX;
					next_cnt   = 3'h0;
					next_idx   = idx_inc;
					next_shreg = tx_pick(idx_inc, tx0, tx1);
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!port_en) begin
			next_state = ST_IDLE;
		end else if (start_ev) begin
			next_state = ST_ADDR;
			next_cnt   = 3'h0;
			next_full  = 1'b0;
		end else if (stop_ev) begin
			next_state = ST_IDLE;
		end
		// drive low for acks and zero data bits
		next_oe = (next_state == ST_AACK)
			| ((next_state == ST_RACK) & (next_idx != 2'h2))
			| ((next_state == ST_TX) & ~next_shreg[7]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ST_IDLE;
			cnt      <= 3'h0;
			shreg    <= RST_BYTE;
			full     <= 1'b0;
			rw       <= 1'b0;
			idx      <= 2'h0;
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
		end else begin
			state    <= next_state;
			cnt      <= next_cnt;
			shreg    <= next_shreg;
			full     <= next_full;
			rw       <= next_rw;
			idx      <= next_idx;
			sda_oe_o <= next_oe;
			sda_o    <= 1'b0;
		end
	end

	// ***************************
	// flag events
	// ***************************
	// byte order and overrun test
	wire st0 = rx_st & (idx == 2'h0);
	wire st1 = rx_st & (idx == 2'h1);
	wire [5:0] set_fl = {
		tx_dn & (idx == 2'h1),    // second transmit done
		tx_dn & (idx == 2'h0),    // first transmit done
		st1 & flags[FL_RX1],      // second overflow
		st1,                      // second receive done
		st0 & flags[FL_RX0],      // first overflow
		st0                       // first receive done
	};
	wire fl_wr  = we_i && (addr_i == ADDR_FLAGS);
	wire [5:0] fl_keep = fl_wr ? wdata_i[5:0] : 6'h3F;
	wire is_rd  = re_i && (addr_i == ADDR_ISTAT);

	// ***************************
	// register file
	// ***************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx0   <= RST_BYTE;
			rx1   <= RST_BYTE;
			tx0   <= RST_BYTE;
			tx1   <= RST_BYTE;
			ctl   <= 4'h0;
			flags <= RST_FLAGS;
			istat <= RST_FLAGS;
			imask <= RST_FLAGS;
		end else begin
			if (st0) begin
				rx0 <= rx_byte;
			end
			if (st1) begin
				rx1 <= rx_byte;
			end
			if (we_i && addr_i == ADDR_TX0) begin
				tx0 <= wdata_i;
			end
			if (we_i && addr_i == ADDR_TX1) begin
				tx1 <= wdata_i;
			end
			// enable, irq enable and address bits
			if (we_i && addr_i == ADDR_CTL) begin
				ctl <= wdata_i[3:0];
			end
			if (we_i && addr_i == ADDR_IMASK) begin
				imask <= wdata_i[5:0];
			end
			// hardware set wins over the clear
			flags <= (flags & fl_keep) | set_fl;
			istat <= (is_rd ? RST_FLAGS : istat) | set_fl;
		end
	end

	always_comb begin
		if (addr_i == ADDR_RX0) begin
			rd_mux = rx0;
		end else if (addr_i == ADDR_RX1) begin
			rd_mux = rx1;
		end else if (addr_i == ADDR_TX0) begin
			rd_mux = tx0;
		end else if (addr_i == ADDR_TX1) begin
			rd_mux = tx1;
		end else if (addr_i == ADDR_CTL) begin
			rd_mux = {4'h0, ctl};
		end else if (addr_i == ADDR_FLAGS) begin
			rd_mux = {2'h0, flags};
		end else if (addr_i == ADDR_ISTAT) begin
			rd_mux = {2'h0, istat};
		end else if (addr_i == ADDR_IMASK) begin
			rd_mux = {2'h0, imask};
		end else begin
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			irq_o   <= 1'b0;
		end else begin
			rdata_o <= re_i ? rd_mux : 8'h00;
			irq_o   <= (tx_ie & (flags[FL_TX1] | flags[FL_TX0]))
				| (|(istat & imask));
		end
	end

	// ***************************
	// assertions
	// ***************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_disabled_quiet;
		!port_en |=> !sda_oe_o && state == ST_IDLE;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("bus driven while disabled");

	property p_tx_irq;
		tx_ie && (flags[FL_TX1] || flags[FL_TX0]) |=> irq_o;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit irq missing");

	property p_irq_drop;
		!(tx_ie && (flags[FL_TX1] || flags[FL_TX0])) && !(|(istat & imask)) |=> !irq_o;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq without cause");

	property p_addr_miss;
		state == ST_ADDR && scl_fall && full && !addr_hit && port_en
			&& !start_ev |=> state == ST_IDLE && !sda_oe_o;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("acked foreign address");

	sequence s_store0;
		st0 ##1 state == ST_RX;
	endsequence
	sequence s_ack0;
		state == ST_RACK && idx == 2'h0 && scl_fall && port_en;
	endsequence
	property p_rx0_store;
		st0 |=> rx0 == $past(rx_byte) && flags[FL_RX0];
	endproperty
	a_rx0_store: assert property (p_rx0_store) else $error("byte zero not stored");

	property p_ov0;
		st0 && flags[FL_RX0] |=> flags[FL_OV0];
	endproperty
	a_ov0: assert property (p_ov0) else $error("first overflow missed");

	property p_rx1;
		st1 && flags[FL_RX1] |=> flags[FL_RX1] && flags[FL_OV1] && rx1 == $past(rx_byte);
	endproperty
	a_rx1: assert property (p_rx1) else $error("second receive flags wrong");

	property p_tx_done;
		tx_dn && idx == 2'h0 && port_en |=> flags[FL_TX0] && state == ST_TACK && !sda_oe_o;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("first transmit flag missed");

	property p_tx1_done;
		tx_dn && idx == 2'h1 && port_en |=> flags[FL_TX1] && state == ST_TACK;
	endproperty
	a_tx1_done: assert property (p_tx1_done) else $error("second transmit flag missed");

	property p_flag_clear;
		fl_wr && !wdata_i[FL_TX0] && !set_fl[FL_TX0] |=> !flags[FL_TX0];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_tx_load;
		state == ST_AACK && scl_fall && rw && port_en && !start_ev && !stop_ev
			|=> shreg == $past(tx0) && sda_oe_o == !shreg[7];
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit byte not loaded");

	property p_rx1_done;
		st1 |=> flags[FL_RX1] && rx1 == $past(rx_byte);
	endproperty
	a_rx1_done: assert property (p_rx1_done) else $error("second receive flag missed");

	// first byte must leave register one untouched
	property p_order;
		s_store0 |-> idx == 2'h0 && rx1 == $past(rx1);
	endproperty
	a_order: assert property (p_order) else $error("byte order broken");

	// the ack after byte zero steers the next byte to register one
	property p_idx_step;
		s_ack0 |=> idx == 2'h1 && state == ST_RX;
	endproperty
	a_idx_step: assert property (p_idx_step) else $error("second byte not steered");
endmodule

// *** common/ssp_pkg.sv ***
// package: register map, field layout and states of the slave i2c port
// Function
// - the port joins bus traffic only while the enable bit is one
// - control bit enables the interrupt from finished transmissions
// - the two lowest slave address bits come from a control field
// - two read-only receive bytes hold master data, zero after reset
// - two writable transmit bytes are sent to the master, zero after reset
// - second transmit done flag sets when byte one is fully shifted out
// - first transmit done flag sets when byte zero is fully shifted out
// - second receive overflow flag sets when byte one is overrun
// - second receive done flag sets when byte one is received
// - first receive overflow flag sets when byte zero is overrun
// - first receive done flag sets when byte zero is received
// - writing zero clears a flag, writing one leaves it alone
package ssp_pkg;
	// ***************************
	// register offsets
	// ***************************
	localparam logic [7:0] ADDR_RX0   = 8'h1A;
	localparam logic [7:0] ADDR_RX1   = 8'h1B;
	localparam logic [7:0] ADDR_TX0   = 8'h1C;
	localparam logic [7:0] ADDR_TX1   = 8'h1D;
	localparam logic [7:0] ADDR_CTL   = 8'h1E;
	localparam logic [7:0] ADDR_FLAGS = 8'h1F;
	localparam logic [7:0] ADDR_ISTAT = 8'h18;
	localparam logic [7:0] ADDR_IMASK = 8'h19;
	// ***************************
	// field positions
	// ***************************
	localparam int CTL_EN = 3;
	localparam int CTL_IE = 2;
	localparam int FL_TX1 = 5;
	localparam int FL_TX0 = 4;
	localparam int FL_OV1 = 3;
	localparam int FL_RX1 = 2;
	localparam int FL_OV0 = 1;
	localparam int FL_RX0 = 0;
	// ***************************
	// reset values and constants
	// ***************************
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	// arbitrary default for the fixed upper address bits
	localparam logic [4:0] ADDR_HIGH_DEF = 5'h0A;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_RX,
		ST_RACK,
		ST_TX,
		ST_TACK
	} ssp_state_e;
endpackage

// *** bench/ssp_i2c_master.sv ***
// bus master model that drives the slave port's i2c pins
`timescale 1ns/1ps
module ssp_i2c_master (
	// clock
	input  wire logic clk_i,
	// bus pins
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// bus clock stands high and the data line is released outside frames
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// quarter of a 160 ns bus clock
	task automatic q();
		repeat (2) @(posedge clk_i);
	endtask
	task automatic start();
		q();
		sda_oe_o <= 1'b1;
		q();
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		q();
		sda_oe_o <= 1'b1;
		q();
		scl_o <= 1'b1;
		q();
		sda_oe_o <= 1'b0;
		q();
	endtask
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_oe_o <= !b;
		q();
		scl_o <= 1'b1;
		q();
		r = sda_i;
		q();
		scl_o <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
endmodule

// *** bench/slave_i2c_two_byte_port_tb.sv ***
// self-checking bench of the slave i2c port
`timescale 1ns/1ps
module slave_i2c_two_byte_port_tb;
	import ssp_pkg::*;
	logic       clk_i;
	logic       rst_i;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic       we_i;
	logic       re_i;
	logic [7:0] rdata_o;
	logic       irq_o;
	logic       sda_o;
	logic       sda_oe_o;
	logic       scl;
	logic       m_oe;
	logic       sda;
	logic [7:0] v;
	logic       a;
	int         fail_count;
	int         tests_run;
	// open-drain line with pull-up; the slave pulls low only while it drives a zero
	assign sda = !(m_oe || (sda_oe_o && !sda_o));
	ssp_slave_port #(.ADDR_HIGH(ADDR_HIGH_DEF)) ssp_slave_port_inst (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	ssp_i2c_master ssp_i2c_master_inst (
		.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
	always #10 clk_i = ~clk_i;
	// ***************
	// helpers
	// ***************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= ad;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask
	task automatic ichk(input logic exp);
		repeat (2) @(posedge clk_i);
		#1;
		chk({7'h00, irq_o}, {7'h00, exp});
	endtask
	task automatic adr(input logic [1:0] id, input logic rw);
		ssp_i2c_master_inst.start();
		ssp_i2c_master_inst.wbyte({ADDR_HIGH_DEF, id, rw}, a);
	endtask
	task automatic wbyte(input logic [7:0] d);
		ssp_i2c_master_inst.wbyte(d, a);
	endtask
	// ***************
	// scenarios
	// ***************
	task automatic t_reset();
		rchk(ADDR_RX0, 8'h00);
		rchk(ADDR_RX1, 8'h00);
		rchk(ADDR_TX0, 8'h00);
		rchk(ADDR_CTL, 8'h00);
		rchk(ADDR_FLAGS, 8'h00);
		wr(ADDR_RX0, 8'h5A);
		rchk(ADDR_RX0, 8'h00);
		wr(ADDR_TX1, 8'hC3);
		rchk(ADDR_TX1, 8'hC3);
		rchk(8'h00, 8'h00);
		adr(2'd0, 1'b0);
		ssp_i2c_master_inst.stop();
		chk({7'h00, a}, 8'h00);
	endtask
	task automatic t_ids();
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTL, 8'h08 | 8'(i));
			adr(2'(i), 1'b0);
			ssp_i2c_master_inst.stop();
			chk({7'h00, a}, 8'h01);
			adr(2'(i) ^ 2'd1, 1'b0);
			ssp_i2c_master_inst.stop();
			chk({7'h00, a}, 8'h00);
		end
	endtask
	task automatic t_write();
		adr(2'd3, 1'b0);
		wbyte(8'h96);
		wbyte(8'h4B);
		chk({7'h00, a}, 8'h01);
		wbyte(8'hE1);
		ssp_i2c_master_inst.stop();
		chk({7'h00, a}, 8'h00);
		rchk(ADDR_RX0, 8'h96);
		rchk(ADDR_RX1, 8'h4B);
		rchk(ADDR_FLAGS, 8'h05);
		adr(2'd3, 1'b0);
		wbyte(8'h11);
		wbyte(8'h22);
		ssp_i2c_master_inst.stop();
		rchk(ADDR_FLAGS, 8'h0F);
		wr(ADDR_FLAGS, 8'hFA);
		rchk(ADDR_FLAGS, 8'h0A);
		rchk(ADDR_ISTAT, 8'h0F);
		rchk(ADDR_ISTAT, 8'h00);
		wr(ADDR_FLAGS, 8'h00);
		rchk(ADDR_FLAGS, 8'h00);
	endtask
	task automatic t_read();
		wr(ADDR_TX0, 8'hA5);
		wr(ADDR_TX1, 8'h3C);
		adr(2'd3, 1'b1);
		ssp_i2c_master_inst.rbyte(1'b0, v);
		chk(v, 8'hA5);
		ssp_i2c_master_inst.rbyte(1'b1, v);
		ssp_i2c_master_inst.stop();
		chk(v, 8'h3C);
		rchk(ADDR_FLAGS, 8'h30);
		ichk(1'b0);
		wr(ADDR_IMASK, 8'h30);
		ichk(1'b1);
		rchk(ADDR_ISTAT, 8'h30);
		ichk(1'b0);
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_CTL, 8'h0F);
		ichk(1'b1);
		wr(ADDR_FLAGS, 8'hEF);
		ichk(1'b1);
		wr(ADDR_FLAGS, 8'hCF);
		ichk(1'b0);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		we_i = 1'b0;
		re_i = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_ids();
		t_write();
		t_read();
		stop_test();
	end
	// run needs about 1600 cycles
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
endmodule
